// *** hw/upic_pkg.sv ***
// upic_pkg: register map, field positions, reset values and carriers
// for the usb power and interrupt control block.
// assumes registers sit one per aligned 32-bit word, byte address = 4 * index.
package upic_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // bus geometry
   localparam int unsigned ADDR_W  = 12;
   localparam int unsigned DATA_W  = 32;
   localparam int unsigned REG_W   = 8;
   localparam int unsigned FLAG_W  = 4;
   localparam int unsigned IDX_LSB = 2;
   localparam int unsigned IDX_MSB = 9;

   localparam logic [7:0] IDX_POWER     = 8'h01;
   localparam logic [7:0] IDX_IN_FLAGS  = 8'h02;
   localparam logic [7:0] IDX_OUT_FLAGS = 8'h04;
   localparam logic [7:0] IDX_CM_FLAGS  = 8'h06;
   localparam logic [7:0] IDX_IN_EN     = 8'h07;
   localparam logic [7:0] IDX_OUT_EN    = 8'h09;
   localparam logic [7:0] IDX_CM_EN     = 8'h0B;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   ////////////////////////////////////////////////////////////////////////////
   // power/control fields
   localparam int unsigned PWR_HOLD_BIT   = 7;
   localparam int unsigned PWR_INH_BIT    = 4;
   localparam int unsigned PWR_RST_BIT    = 3;
   localparam int unsigned PWR_RESUME_BIT = 2;
   localparam int unsigned PWR_SUSP_BIT   = 1;
   localparam int unsigned PWR_SDEN_BIT   = 0;

   // common flag / enable fields
   localparam int unsigned CM_SOF_BIT = 3;
   localparam int unsigned CM_RST_BIT = 2;
   localparam int unsigned CM_RSU_BIT = 1;
   localparam int unsigned CM_SUS_BIT = 0;

   ////////////////////////////////////////////////////////////////////////////
   // reset values and masks
   localparam logic [REG_W-1:0]  POWER_RST    = 8'h10;
   localparam logic [FLAG_W-1:0] FLAGS_RST    = 4'h0;
   localparam logic [FLAG_W-1:0] IN_EN_RST    = 4'hF;
   localparam logic [FLAG_W-1:0] OUT_EN_RST   = 4'hE;
   localparam logic [FLAG_W-1:0] CM_EN_RST    = 4'h6;
   localparam logic [FLAG_W-1:0] CM_EN_BUSRST = 4'hE;
   localparam logic [FLAG_W-1:0] IN_MASK      = 4'hF;
   localparam logic [FLAG_W-1:0] OUT_MASK     = 4'hE;

   ////////////////////////////////////////////////////////////////////////////
   // carriers
   typedef struct packed {
      logic       reset_signal;
      logic       suspend_detect;
      logic       resume_detect;
      logic       sof_expected;
      logic       iso_sof_token;
      logic       in_packet_ready;
      logic [3:0] in_done;
      logic [3:1] out_done;
   } upic_sie_evt_t;

   typedef struct packed {
      logic function_enable;
      logic resume_drive;
      logic core_reset;
      logic bus_reset_clear;
      logic iso_send_packet;
      logic iso_send_zero_len;
      logic suspended;
   } upic_ctl_t;

endpackage

// *** hw/upic_core.sv ***
// upic_core: device-level power/control register and interrupt flags
// of a full/low speed usb function controller, with an axi4-lite slave.
// assumes the serial interface engine runs on aclk and delivers its
// events as one-cycle pulses and its bus reset state as a level.
//
// Contract
// - hold clear: ready isochronous packet goes out on the next in token.
// - hold set: packet waits for start-of-frame; earlier in token gets zero length.
// - inhibit set by resets; software may only clear it, never set it.
// - while inhibited, all bus traffic is ignored; clear enables the function.
// - writing one to reset-detect position resets the whole function controller.
// - reset-detect bit reads one while bus reset signaling is present.
// - writing force-resume one while suspended drives remote wakeup resume signaling.
// - writing force-resume zero while it is one raises an interrupt and clears suspend state.
// - suspend state set on suspend; cleared by resume end or flag read after bus resume.
// - suspend-detect enable zero ignores suspend; one enters suspend on detection.
// - interrupt request asserts whenever an enabled interrupt-pending flag is set.
// - reading a flag register returns flags and clears all of them.
// - in flags: control endpoint bit 0, in endpoints 1 to 3 bits 1-3.
// - out flags: out endpoints 1 to 3 at bits 1-3, bit 0 zero.
// - bits 7 to 4 of flag and enable registers read zero.
// - start-of-frame flag set at each expected frame start, token or not.
// - reset pending flag set when bus reset signaling is detected.
// - resume pending flag set on bus resume only while suspended.
// - suspend pending flag set on suspend only while detection enabled.
// - in enable register: four enables, all one after reset.
// - out enable register: enables at bits 1-3, all one after reset.
// - bus reset clears address, fifos, control; enables all but suspend.
// - suspend left on resume, bus reset, or device or usb reset.
`timescale 1ns/100ps

module upic_core (
   input  wire logic                          aclk,
   input  wire logic                          aresetn,
   input  wire logic                          clk_en,
   input  wire logic [upic_pkg::ADDR_W-1:0]   s_axi_awaddr,
   input  wire logic                          s_axi_awvalid,
   output logic                               s_axi_awready,
   input  wire logic [upic_pkg::DATA_W-1:0]   s_axi_wdata,
   input  wire logic [3:0]                    s_axi_wstrb,
   input  wire logic                          s_axi_wvalid,
   output logic                               s_axi_wready,
   output logic [1:0]                         s_axi_bresp,
   output logic                               s_axi_bvalid,
   input  wire logic                          s_axi_bready,
   input  wire logic [upic_pkg::ADDR_W-1:0]   s_axi_araddr,
   input  wire logic                          s_axi_arvalid,
   output logic                               s_axi_arready,
   output logic [upic_pkg::DATA_W-1:0]        s_axi_rdata,
   output logic [1:0]                         s_axi_rresp,
   output logic                               s_axi_rvalid,
   input  wire logic                          s_axi_rready,
   input  wire upic_pkg::upic_sie_evt_t       sie_evt,
   output upic_pkg::upic_ctl_t                ctl,
   output logic                               usb_irq
);

   ////////////////////////////////////////////////////////////////////////////
   // declarations
   logic                            aw_full_r;
   logic [upic_pkg::ADDR_W-1:0]     aw_addr_r;
   logic                            w_full_r;
   logic [upic_pkg::REG_W-1:0]      w_byte_r;
   logic                            w_lane0_r;
   logic                            bvalid_r;
   logic [1:0]                      bresp_r;
   logic                            rvalid_r;
   logic [upic_pkg::DATA_W-1:0]     rdata_r;
   logic [1:0]                      rresp_r;

   logic                            wr_fire;
   logic                            rd_fire;
   logic [7:0]                      wr_idx;
   logic [7:0]                      rd_idx;
   logic                            wr_aligned;
   logic                            rd_aligned;
   logic                            wr_mapped;
   logic                            rd_mapped;
   logic                            wr_en;
   logic                            wr_power;

   logic                            soft_rst_r;
   logic                            regs_rst;
   logic                            hold_r;
   logic                            inhibit_r;
   logic                            sden_r;
   logic                            resume_r;
   logic                            susp_r;
   logic                            resume_seen_r;
   logic                            bus_rst_d_r;
   logic                            resume_end;

   logic [upic_pkg::FLAG_W-1:0]     in_flags_r;
   logic [upic_pkg::FLAG_W-1:0]     out_flags_r;
   logic [upic_pkg::FLAG_W-1:0]     cm_flags_r;
   logic [upic_pkg::FLAG_W-1:0]     in_en_r;
   logic [upic_pkg::FLAG_W-1:0]     out_en_r;
   logic [upic_pkg::FLAG_W-1:0]     cm_en_r;
   logic [upic_pkg::FLAG_W-1:0]     in_set;
   logic [upic_pkg::FLAG_W-1:0]     out_set;
   logic [upic_pkg::FLAG_W-1:0]     cm_set;
   logic                            rd_in_flags;
   logic                            rd_out_flags;
   logic                            rd_cm_flags;

   logic                            active;
   logic                            ev_bus_rst;
   logic                            ev_susp;
   logic                            ev_resume;
   logic                            ev_sof;
   logic                            iso_armed_r;
   logic                            irq_r;
   logic                            irq_nxt;
   upic_pkg::upic_ctl_t             ctl_r;
   upic_pkg::upic_ctl_t             ctl_nxt;
   logic [upic_pkg::REG_W-1:0]      rd_byte;
   logic [upic_pkg::REG_W-1:0]      power_view;

   ////////////////////////////////////////////////////////////////////////////
   // axi4-lite handshakes
   assign s_axi_awready = clk_en && aresetn && !aw_full_r;
   assign s_axi_wready  = clk_en && aresetn && !w_full_r;
   assign s_axi_arready = clk_en && aresetn && !rvalid_r;
   assign s_axi_bvalid  = bvalid_r;
   assign s_axi_bresp   = bresp_r;
   assign s_axi_rvalid  = rvalid_r;
   assign s_axi_rdata   = rdata_r;
   assign s_axi_rresp   = rresp_r;

   assign wr_fire = clk_en && aw_full_r && w_full_r && !bvalid_r;
   assign rd_fire = s_axi_arvalid && s_axi_arready;

   assign wr_idx     = aw_addr_r[upic_pkg::IDX_MSB:upic_pkg::IDX_LSB];
   assign rd_idx     = s_axi_araddr[upic_pkg::IDX_MSB:upic_pkg::IDX_LSB];
   assign wr_aligned = (aw_addr_r[upic_pkg::IDX_LSB-1:0] == 2'h0)
                       && (aw_addr_r[upic_pkg::ADDR_W-1:upic_pkg::IDX_MSB+1] == 2'h0);
   assign rd_aligned = (s_axi_araddr[upic_pkg::IDX_LSB-1:0] == 2'h0)
                       && (s_axi_araddr[upic_pkg::ADDR_W-1:upic_pkg::IDX_MSB+1] == 2'h0);

   function automatic logic idx_known(input logic [7:0] idx);
      idx_known = (idx == upic_pkg::IDX_POWER) || (idx == upic_pkg::IDX_IN_FLAGS)
                  || (idx == upic_pkg::IDX_OUT_FLAGS) || (idx == upic_pkg::IDX_CM_FLAGS)
                  || (idx == upic_pkg::IDX_IN_EN) || (idx == upic_pkg::IDX_OUT_EN)
                  || (idx == upic_pkg::IDX_CM_EN);
   endfunction

   assign wr_mapped = wr_aligned && idx_known(wr_idx);
   assign rd_mapped = rd_aligned && idx_known(rd_idx);
   assign wr_en     = wr_fire && wr_mapped && w_lane0_r;
   assign wr_power  = wr_en && (wr_idx == upic_pkg::IDX_POWER);

   // write address and data captured independently
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_full_r <= 1'b0;
         aw_addr_r <= '0;
      end
      else if (clk_en)
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_full_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
         end
         else if (wr_fire)
            aw_full_r <= 1'b0;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         w_full_r  <= 1'b0;
         w_byte_r  <= '0;
         w_lane0_r <= 1'b0;
      end
      else if (clk_en)
      begin
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_full_r  <= 1'b1;
            w_byte_r  <= s_axi_wdata[upic_pkg::REG_W-1:0];
            w_lane0_r <= s_axi_wstrb[0];
         end
         else if (wr_fire)
            w_full_r <= 1'b0;
      end
   end

   // write response
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         bvalid_r <= 1'b0;
         bresp_r  <= upic_pkg::RESP_OKAY;
      end
      else if (clk_en)
      begin
         if (wr_fire)
         begin
            bvalid_r <= 1'b1;
            bresp_r  <= wr_mapped ? upic_pkg::RESP_OKAY : upic_pkg::RESP_SLVERR;
         end
         else if (s_axi_bready)
            bvalid_r <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // register read view
   always_comb
   begin
      power_view = '0;
      power_view[upic_pkg::PWR_HOLD_BIT]   = hold_r;
      power_view[upic_pkg::PWR_INH_BIT]    = inhibit_r;
      power_view[upic_pkg::PWR_RST_BIT]    = sie_evt.reset_signal;
      power_view[upic_pkg::PWR_RESUME_BIT] = resume_r;
      power_view[upic_pkg::PWR_SUSP_BIT]   = susp_r;
      power_view[upic_pkg::PWR_SDEN_BIT]   = sden_r;
   end

   always_comb
   begin
      rd_byte = '0;
      unique case (rd_idx)
         upic_pkg::IDX_POWER:     rd_byte = power_view;
         upic_pkg::IDX_IN_FLAGS:  rd_byte = {4'h0, in_flags_r};
         upic_pkg::IDX_OUT_FLAGS: rd_byte = {4'h0, out_flags_r};
         upic_pkg::IDX_CM_FLAGS:  rd_byte = {4'h0, cm_flags_r};
         upic_pkg::IDX_IN_EN:     rd_byte = {4'h0, in_en_r};
         upic_pkg::IDX_OUT_EN:    rd_byte = {4'h0, out_en_r};
         upic_pkg::IDX_CM_EN:     rd_byte = {4'h0, cm_en_r};
         default:                 rd_byte = '0;
      endcase
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rvalid_r <= 1'b0;
         rdata_r  <= '0;
         rresp_r  <= upic_pkg::RESP_OKAY;
      end
      else if (clk_en)
      begin
         if (rd_fire)
         begin
            rvalid_r <= 1'b1;
            rdata_r  <= rd_mapped ? {24'h0, rd_byte} : '0;
            rresp_r  <= rd_mapped ? upic_pkg::RESP_OKAY : upic_pkg::RESP_SLVERR;
         end
         else if (s_axi_rready)
            rvalid_r <= 1'b0;
      end
   end

   assign rd_in_flags  = rd_fire && rd_mapped && (rd_idx == upic_pkg::IDX_IN_FLAGS);
   assign rd_out_flags = rd_fire && rd_mapped && (rd_idx == upic_pkg::IDX_OUT_FLAGS);
   assign rd_cm_flags  = rd_fire && rd_mapped && (rd_idx == upic_pkg::IDX_CM_FLAGS);

   ////////////////////////////////////////////////////////////////////////////
   // bus events, gated by inhibit
   assign active     = !inhibit_r;
   assign ev_bus_rst = active && sie_evt.reset_signal && !bus_rst_d_r;
   assign ev_susp    = active && sie_evt.suspend_detect && sden_r;
   assign ev_resume  = active && sie_evt.resume_detect && susp_r;
   assign ev_sof     = active && sie_evt.sof_expected;
   assign resume_end = wr_power && resume_r && !w_byte_r[upic_pkg::PWR_RESUME_BIT];

   assign in_set  = active ? sie_evt.in_done : '0;
   assign out_set = active ? ({sie_evt.out_done, 1'b0} & upic_pkg::OUT_MASK) : '0;
   assign cm_set  = {ev_sof, ev_bus_rst, ev_resume || resume_end, ev_susp};

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         bus_rst_d_r <= 1'b0;
      else if (clk_en)
         bus_rst_d_r <= sie_evt.reset_signal;
   end

   ////////////////////////////////////////////////////////////////////////////
   // power/control register
   assign regs_rst = !aresetn || soft_rst_r;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         soft_rst_r <= 1'b0;
      else if (clk_en)
         soft_rst_r <= wr_power && w_byte_r[upic_pkg::PWR_RST_BIT];
   end

   always_ff @(posedge aclk)
   begin
      if (regs_rst)
      begin
         hold_r    <= upic_pkg::POWER_RST[upic_pkg::PWR_HOLD_BIT];
         inhibit_r <= upic_pkg::POWER_RST[upic_pkg::PWR_INH_BIT];
         sden_r    <= upic_pkg::POWER_RST[upic_pkg::PWR_SDEN_BIT];
      end
      else if (clk_en && wr_power)
      begin
         hold_r <= w_byte_r[upic_pkg::PWR_HOLD_BIT];
         sden_r <= w_byte_r[upic_pkg::PWR_SDEN_BIT];
         if (!w_byte_r[upic_pkg::PWR_INH_BIT])
            inhibit_r <= 1'b0;
      end
   end

   // remote wakeup resume drive
   always_ff @(posedge aclk)
   begin
      if (regs_rst)
         resume_r <= upic_pkg::POWER_RST[upic_pkg::PWR_RESUME_BIT];
      else if (clk_en && wr_power)
      begin
         if (!w_byte_r[upic_pkg::PWR_RESUME_BIT])
            resume_r <= 1'b0;
         else if (susp_r)
            resume_r <= 1'b1;
      end
   end

   // suspend state; bus reset clear wins over entry, entry wins over the other clears
   always_ff @(posedge aclk)
   begin
      if (regs_rst)
         susp_r <= upic_pkg::POWER_RST[upic_pkg::PWR_SUSP_BIT];
      else if (clk_en)
      begin
         if (ev_bus_rst)
            susp_r <= 1'b0;
         else if (ev_susp)
            susp_r <= 1'b1;
         else if (resume_end || (rd_cm_flags && resume_seen_r))
            susp_r <= 1'b0;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (regs_rst)
         resume_seen_r <= 1'b0;
      else if (clk_en)
      begin
         if (ev_resume)
            resume_seen_r <= 1'b1;
         else if (rd_cm_flags || ev_bus_rst)
            resume_seen_r <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // interrupt flags: set wins over clear-on-read
   always_ff @(posedge aclk)
   begin
      if (regs_rst)
      begin
         in_flags_r  <= upic_pkg::FLAGS_RST;
         out_flags_r <= upic_pkg::FLAGS_RST;
         cm_flags_r  <= upic_pkg::FLAGS_RST;
      end
      else if (clk_en)
      begin
         if (ev_bus_rst)
         begin
            in_flags_r  <= in_set;
            out_flags_r <= out_set;
            cm_flags_r  <= cm_set;
         end
         else
         begin
            in_flags_r  <= (rd_in_flags ? '0 : in_flags_r) | in_set;
            out_flags_r <= (rd_out_flags ? '0 : out_flags_r) | out_set;
            cm_flags_r  <= (rd_cm_flags ? '0 : cm_flags_r) | cm_set;
         end
      end
   end

   // interrupt enables
   always_ff @(posedge aclk)
   begin
      if (regs_rst)
      begin
         in_en_r  <= upic_pkg::IN_EN_RST;
         out_en_r <= upic_pkg::OUT_EN_RST;
         cm_en_r  <= upic_pkg::CM_EN_RST;
      end
      else if (clk_en)
      begin
         if (ev_bus_rst)
         begin
            in_en_r  <= upic_pkg::IN_EN_RST;
            out_en_r <= upic_pkg::OUT_EN_RST;
            cm_en_r  <= upic_pkg::CM_EN_BUSRST;
         end
         else if (wr_en)
         begin
            if (wr_idx == upic_pkg::IDX_IN_EN)
               in_en_r <= w_byte_r[upic_pkg::FLAG_W-1:0] & upic_pkg::IN_MASK;
            if (wr_idx == upic_pkg::IDX_OUT_EN)
               out_en_r <= w_byte_r[upic_pkg::FLAG_W-1:0] & upic_pkg::OUT_MASK;
            if (wr_idx == upic_pkg::IDX_CM_EN)
               cm_en_r <= w_byte_r[upic_pkg::FLAG_W-1:0];
         end
      end
   end

   // request: any enabled pending flag
   assign irq_nxt = |(in_flags_r & in_en_r) || |(out_flags_r & out_en_r)
                    || |(cm_flags_r & cm_en_r);

   always_ff @(posedge aclk)
   begin
      if (regs_rst)
         irq_r <= 1'b0;
      else if (clk_en)
         irq_r <= irq_nxt;
   end

   assign usb_irq = irq_r;

   ////////////////////////////////////////////////////////////////////////////
   // isochronous in release
   always_ff @(posedge aclk)
   begin
      if (regs_rst)
         iso_armed_r <= 1'b0;
      else if (clk_en)
      begin
         if (!sie_evt.in_packet_ready)
            iso_armed_r <= 1'b0;
         else if (active && sie_evt.iso_sof_token)
            iso_armed_r <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // control outputs
   always_comb
   begin
      ctl_nxt                   = '0;
      ctl_nxt.function_enable   = active;
      ctl_nxt.resume_drive      = resume_r;
      ctl_nxt.core_reset        = soft_rst_r;
      ctl_nxt.bus_reset_clear   = ev_bus_rst;
      ctl_nxt.iso_send_packet   = active && sie_evt.in_packet_ready
                                  && (!hold_r || iso_armed_r);
      ctl_nxt.iso_send_zero_len = active && sie_evt.in_packet_ready
                                  && hold_r && !iso_armed_r;
      ctl_nxt.suspended         = susp_r;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         ctl_r <= '0;
      else if (clk_en)
         ctl_r <= ctl_nxt;
   end

   assign ctl = ctl_r;

endmodule

// *** verif/upic_assertions.sv ***
// upic_assertions: port-level checks of upic_core
// assumes clk_en held high and one aclk domain
`timescale 1ns/100ps
module upic_assertions (
   input wire logic                    aclk,
   input wire logic                    aresetn,
   input wire upic_pkg::upic_sie_evt_t sie_evt,
   input wire upic_pkg::upic_ctl_t     ctl,
   input wire logic                    usb_irq
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   ////////////////////////////////////////////////////////////////////////////
   sequence s_ep1;
      sie_evt.in_done[1] && ctl.function_enable;
   endsequence
   sequence s_quiet;
      !ctl.function_enable ##1 !ctl.function_enable;
   endsequence
   property p_irq;
      s_ep1 |=> ##1 usb_irq;
   endproperty
   a_irq: assert property (p_irq) else $error("no irq after flag");
   property p_wake;
      $rose(ctl.resume_drive) |-> $past(ctl.suspended);
   endproperty
   a_wake: assert property (p_wake) else $error("resume while awake");
   property p_rsm_end;
      $fell(ctl.resume_drive) |-> !ctl.suspended;
   endproperty
   a_rsm_end: assert property (p_rsm_end) else $error("suspend kept");
   property p_crst;
      ctl.core_reset |=> !ctl.core_reset ##1 !ctl.function_enable;
   endproperty
   a_crst: assert property (p_crst) else $error("soft reset wrong");
   property p_inh;
      $fell(ctl.function_enable) |-> $past(ctl.core_reset, 2) || $past(ctl.core_reset);
   endproperty
   a_inh: assert property (p_inh) else $error("inhibit set by write");
   property p_brst;
      $rose(sie_evt.reset_signal) && ctl.function_enable |=> ctl.bus_reset_clear;
   endproperty
   a_brst: assert property (p_brst) else $error("bus reset missed");
   property p_bsus;
      ctl.bus_reset_clear |=> !ctl.suspended;
   endproperty
   a_bsus: assert property (p_bsus) else $error("suspend kept on reset");
   property p_iso;
      ctl.iso_send_zero_len |-> !ctl.iso_send_packet;
   endproperty
   a_iso: assert property (p_iso) else $error("iso send clash");
   property p_quiet;
      s_quiet |-> !ctl.bus_reset_clear;
   endproperty
   a_quiet: assert property (p_quiet) else $error("traffic while inhibited");
endmodule
bind upic_core upic_assertions u_upic_assertions (.aclk(aclk), .aresetn(aresetn),
   .sie_evt(sie_evt), .ctl(ctl), .usb_irq(usb_irq));

// *** verif/upic_host_model.sv ***
// upic_host_model: bus side, turns bench requests into sie events
// assumes requests change right after a rising edge
`timescale 1ns/100ps
module upic_host_model (
   input  wire logic                    aclk,
   input  wire logic                    aresetn,
   input  wire upic_pkg::upic_sie_evt_t evt_req,
   output upic_pkg::upic_sie_evt_t      sie_evt
);
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         sie_evt <= '0;
      else
         sie_evt <= evt_req;
   end
endmodule

// *** verif/tb.sv ***
// tb: register-level tests of upic_core over axi4-lite
// assumes upic_host_model delivers bus events
`timescale 1ns/100ps
module tb;
   logic                    aclk, aresetn, awv, wv, bready, arv, rready, irq, awr, wrdy, bv;
   logic                    arr, rv, rs;
   logic [11:0]             awaddr, araddr;
   logic [31:0]             wdata, rdata, rdat;
   logic [1:0]              bresp, rresp, rrsp;
   int                      bad_count, total_checks;
   upic_pkg::upic_sie_evt_t req, evt;
   upic_pkg::upic_ctl_t     ctl;
   upic_host_model u_upic_host_model (.aclk(aclk), .aresetn(aresetn), .evt_req(req),
      .sie_evt(evt));
   upic_core u_upic_core (.aclk(aclk), .aresetn(aresetn), .clk_en(1'b1),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_bresp(bresp),
      .s_axi_bvalid(bv), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arv),
      .s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
      .s_axi_rready(rready), .sie_evt(evt), .ctl(ctl), .usb_irq(irq));
   initial
   begin
      aclk = 0;
      forever #12.5 aclk = ~aclk;
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic cmp(string n, logic [31:0] e, logic [31:0] g);
      total_checks++;
      if (g !== e)
      begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic tmo(logic ok);
      if (ok !== 1'b1)
      begin
         bad_count++;
         give_verdict();
      end
   endtask
   task automatic wr(logic [7:0] i, logic [7:0] d);
      logic a, w;
      a = 0;
      w = 0;
      @(posedge aclk);
      awaddr <= {2'h0, i, 2'h0};
      wdata <= {24'h0, d};
      awv <= 1'b1;
      wv <= 1'b1;
      for (int n = 0; n < 50 && !(a && w); n++)
      begin
         @(posedge aclk);
         if (awv && awr) a = 1;
         if (wv && wrdy) w = 1;
         if (a) awv <= 1'b0;
         if (w) wv <= 1'b0;
      end
      bready <= 1'b1;
      a = 0;
      for (int n = 0; n < 50 && !a; n++)
      begin
         @(posedge aclk);
         a = bv;
      end
      bready <= 1'b0;
      tmo(a);
   endtask
   task automatic rd(logic [7:0] i);
      logic g;
      g = 0;
      @(posedge aclk);
      araddr <= {2'h0, i, 2'h0};
      arv <= 1'b1;
      for (int n = 0; n < 50 && !g; n++)
      begin
         @(posedge aclk);
         g = arr;
      end
      arv <= 1'b0;
      rready <= 1'b1;
      g = 0;
      for (int n = 0; n < 50 && !g; n++)
      begin
         @(posedge aclk);
         g = rv;
         rdat = rdata;
         rrsp = rresp;
      end
      rready <= 1'b0;
      tmo(g);
   endtask
   task automatic rc(string n, logic [7:0] i, logic [7:0] e);
      rd(i);
      cmp(n, {24'h0, e}, rdat);
   endtask
   task automatic ev(upic_pkg::upic_sie_evt_t e);
      @(posedge aclk);
      e.reset_signal = rs;
      req <= e;
      @(posedge aclk);
      e = '0;
      e.reset_signal = rs;
      req <= e;
      repeat (3) @(posedge aclk);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      {aresetn, awv, wv, bready, arv, rready, rs, awaddr, araddr, wdata, req} = '0;
      bad_count = 0;
      total_checks = 0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      ev('{in_done: 4'hF, default: '0});
      rc("in_flags", 8'h02, 8'h00);
      rc("power", 8'h01, 8'h10);
      rc("in_en", 8'h07, 8'h0F);
      rc("out_en", 8'h09, 8'h0E);
      rd(8'h03);
      cmp("resp", {30'h0, upic_pkg::RESP_SLVERR}, {30'h0, rrsp});
      wr(8'h01, 8'h01);
      wr(8'h01, 8'h11);
      rc("power", 8'h01, 8'h01);
      ev('{in_done: 4'hF, out_done: 3'h7, default: '0});
      cmp("irq", 32'h1, {31'h0, irq});
      rc("in_flags", 8'h02, 8'h0F);
      rc("in_flags", 8'h02, 8'h00);
      rc("out_flags", 8'h04, 8'h0E);
      wr(8'h07, 8'hFE);
      rc("in_en", 8'h07, 8'h0E);
      ev('{in_done: 4'h1, default: '0});
      cmp("irq", 32'h0, {31'h0, irq});
      rc("in_flags", 8'h02, 8'h01);
      ev('{suspend_detect: 1'b1, default: '0});
      rc("power", 8'h01, 8'h03);
      wr(8'h01, 8'h05);
      rc("power", 8'h01, 8'h07);
      wr(8'h01, 8'h01);
      rc("power", 8'h01, 8'h01);
      rc("cm_flags", 8'h06, 8'h03);
      ev('{suspend_detect: 1'b1, default: '0});
      ev('{resume_detect: 1'b1, default: '0});
      rc("power", 8'h01, 8'h03);
      rc("cm_flags", 8'h06, 8'h03);
      rc("power", 8'h01, 8'h01);
      ev('{sof_expected: 1'b1, default: '0});
      rc("cm_flags", 8'h06, 8'h08);
      req <= '{in_packet_ready: 1'b1, default: '0};
      repeat (3) @(posedge aclk);
      cmp("iso_send", 32'h1, {31'h0, ctl.iso_send_packet});
      wr(8'h01, 8'h80);
      @(posedge aclk);
      cmp("iso_zero", 32'h1, {31'h0, ctl.iso_send_zero_len});
      req <= '{in_packet_ready: 1'b1, iso_sof_token: 1'b1, default: '0};
      @(posedge aclk);
      req <= '{in_packet_ready: 1'b1, default: '0};
      repeat (3) @(posedge aclk);
      cmp("iso_send", 32'h1, {31'h0, ctl.iso_send_packet});
      ev('{in_packet_ready: 1'b1, suspend_detect: 1'b1, default: '0});
      rc("power", 8'h01, 8'h80);
      wr(8'h01, 8'h00);
      rs = 1;
      ev('0);
      rc("power", 8'h01, 8'h08);
      rc("cm_flags", 8'h06, 8'h04);
      rc("in_en", 8'h07, 8'h0F);
      rs = 0;
      ev('0);
      wr(8'h01, 8'h08);
      rc("power", 8'h01, 8'h10);
      give_verdict();
   end
endmodule
